/* src/cbc_balance_ctrl.sv */
// Overview of operation
// [RULE1] Junction over-temperature protection always applies while balancing; no disable setting.
// [RULE2] Junction reading above upper threshold interrupts balancing on all channels.
// [RULE3] Channel timers freeze during junction pause; resume below threshold minus hysteresis. The code resumes at or below that level.
// [RULE4] Junction pause leaves the global timeout countdown running.
// [RULE5] Measurement pause inhibits all balancing and holds channel timers.
// [RULE6] Measurement pause leaves the global timeout countdown running.
// [RULE7] Enable key written to discharge control starts full-duty emergency discharge.
// [RULE8] Disable key or supply low-voltage stops emergency discharge.
// [RULE9] Emergency discharge runs without global enable and ignores temperature modulation.
// [RULE10] Timeout expiry never ends discharge; timeout is held while discharge runs.
// [RULE11] Battery overvoltage suspends discharge and releases timeout; flag clear resumes both.
// [RULE12] A switch fault turns off only the affected channel.
// [RULE13] All balancing and diagnostics need global enable, except emergency discharge.
// [RULE14] A channel that completes balancing has its enable bit cleared.
// [RULE15] One periodic measurement per wake-up feeds the voltage-based decisions.
// [RULE16] All channel enables clear: global enable resets and ready status sets.
// [RULE17] Timeout, all timers expired, or undervoltage limits clear the channel enables.
// [RULE18] No register reports why channel enables were cleared.
// [RULE19] Two status registers show each switch open or closed.
// [RULE20] Fault flag sets when a switch state differs from its intended state.
// [RULE21] Status, overcurrent and open-load checks per switch, each switch separately enabled.
// [RULE22] Channel enables live in two registers: channels 0-15 and 16-17.
// [RULE23] Timeout decrements every 10 s while non-zero; expiry opens switches, clears enable.
// [RULE24] Prebalance counter runs once enabled; balancing and channel timers wait for expiry.
// [RULE25] Junction threshold and hysteresis are inputs compared to the latest junction result.
`include "cbc_params.svh"
`default_nettype none

module cbc_balance_ctrl
  import cbc_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `CBC_TIMER_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          nrst,
  // Register access port
  input  wire cbc_reg_req_t  reg_req,
  output logic [15:0]        reg_rdata,
  // Junction temperature result and limits
  input  wire cbc_junction_t junction,
  // Measurement pause and supply conditions
  input  wire logic          meas_pause,
  input  wire logic          supply_low,
  input  wire logic          battery_overvoltage_flag,
  // Completion events from the channel modes
  input  wire cbc_done_t     done_evt,
  // Physical switch feedback
  input  wire logic [17:0]   switch_closed,
  input  wire logic [17:0]   switch_overcurrent,
  input  wire logic [17:0]   switch_open_load,
  // Switch drive and mode outputs
  output logic [17:0]        balance_terminal,
  output logic               channel_timer_hold,
  output logic [3:0]         mode_config
);

  generate
    if (STEP_CYCLES < 2) begin : g_bad_step
      $error("STEP_CYCLES must be at least 2");
    end
  endgenerate

  logic [1:0]  rst_sync;
  logic        rst_n;
  cbc_state_t  s;
  cbc_state_t  next_s;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  function automatic logic [15:0] read_mux(input cbc_state_t st, input logic [15:0] addr);
    logic [15:0] v;
    v = 16'h0000;
    case (addr)
      `CBC_ADDR_GLOBAL_CONFIG: begin
        v[`CBC_BIT_GLOBAL_ENABLE]  = st.enable;
        v[`CBC_BIT_TIMER_MODE]     = st.timer_mode;
        v[`CBC_BIT_CELL_UV_MODE]   = st.cell_uv_mode;
        v[`CBC_BIT_GLOBAL_UV_MODE] = st.global_uv_mode;
      end
      `CBC_ADDR_TIMEOUT_TIMER:    v = st.timeout;
      `CBC_ADDR_CH_ENABLE_LOW:    v = st.ch_enable[15:0];
      `CBC_ADDR_CH_ENABLE_HIGH:   v = {14'h0000, st.ch_enable[17:16]};
      `CBC_ADDR_PREBALANCE_TIMER: v = st.prebalance;
      `CBC_ADDR_DISCHARGE_CTRL:   v = st.discharge_ctrl;
      `CBC_ADDR_MON_ENABLE_LOW:   v = st.mon_enable[15:0];
      `CBC_ADDR_MON_ENABLE_HIGH:  v = {14'h0000, st.mon_enable[17:16]};
      `CBC_ADDR_STATUS_LOW:       v = st.switch_on[15:0];
      `CBC_ADDR_STATUS_HIGH: begin
        v[1:0]         = st.switch_on[17:16];
        v[`CBC_BIT_READY + 2] = st.ready;
      end
      `CBC_ADDR_SWITCH_LOW:       v = switch_closed[15:0]; // [RULE19]
      `CBC_ADDR_SWITCH_HIGH:      v = {14'h0000, switch_closed[17:16]}; // [RULE19]
      `CBC_ADDR_FAULT_LOW:        v = st.fault[15:0];
      `CBC_ADDR_FAULT_HIGH:       v = {14'h0000, st.fault[17:16]};
      default:                    v = 16'h0000;
    endcase
    return v;
  endfunction : read_mux

  logic        run_discharge;
  logic        expire;
  logic        balance_go;
  logic        diag_active;
  logic        clear_all;
  logic [16:0] release_level;
  logic [17:0] mismatch;
  logic [17:0] new_fault;
  logic [17:0] clear_mask;
  logic [17:0] target;

  always_comb begin
    next_s        = s;
    expire        = 1'b0;
    release_level = 17'h00000;
    mismatch      = 18'h00000;
    new_fault     = 18'h00000;
    clear_mask    = 18'h00000;
    target        = 18'h00000;
    clear_all     = 1'b0;

    // 10 s step enable
    next_s.step = 1'b0;
    if (s.step_cnt == STEP_CYCLES - 1) begin
      next_s.step_cnt = 32'h00000000;
      next_s.step     = 1'b1;
    end else begin
      next_s.step_cnt = s.step_cnt + 32'h00000001;
    end

    // Overvoltage only suspends; the request itself stays armed
    run_discharge = s.discharge_on & ~battery_overvoltage_flag; // [RULE11]

    // Timeout runs regardless of pauses, held only by a running discharge
    if (s.step && s.timeout != 16'h0000 && !run_discharge) begin // [RULE4] [RULE6] [RULE10]
      next_s.timeout = s.timeout - 16'h0001; // [RULE23]
      expire         = (s.timeout == 16'h0001);
    end

    if (s.step && s.enable && s.prebalance != 16'h0000) begin
      next_s.prebalance = s.prebalance - 16'h0001; // [RULE24]
    end

    // Junction protection has no enable of its own
    if (junction.valid) begin // [RULE1] [RULE25]
      release_level = {1'b0, junction.temp} + {1'b0, junction.hyst};
      if (junction.temp > junction.upper) begin
        next_s.junction_over = 1'b1; // [RULE2]
      end else if (release_level <= {1'b0, junction.upper}) begin
        next_s.junction_over = 1'b0; // [RULE3]
      end
    end

    balance_go = s.enable & (s.prebalance == 16'h0000) // [RULE13] [RULE24]
               & ~s.junction_over & ~meas_pause; // [RULE2] [RULE5]

    if (run_discharge) begin
      target = ~s.fault; // [RULE7] [RULE9] [RULE12]
    end else if (balance_go) begin
      target = s.ch_enable & ~s.fault; // [RULE12]
    end
    next_s.switch_on      = target;
    next_s.switch_on_prev = s.switch_on;

    // Compare only channels whose command has settled for a cycle
    diag_active = s.enable | run_discharge; // [RULE13]
    if (diag_active) begin
      mismatch  = ((switch_closed ^ s.switch_on) & ~(s.switch_on ^ s.switch_on_prev)) // [RULE20]
                | switch_overcurrent | switch_open_load; // [RULE21]
      new_fault = mismatch & s.mon_enable; // [RULE21]
    end

    // Register writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        `CBC_ADDR_GLOBAL_CONFIG: begin
          next_s.enable         = reg_req.wdata[`CBC_BIT_GLOBAL_ENABLE];
          next_s.timer_mode     = reg_req.wdata[`CBC_BIT_TIMER_MODE];
          next_s.cell_uv_mode   = reg_req.wdata[`CBC_BIT_CELL_UV_MODE];
          next_s.global_uv_mode = reg_req.wdata[`CBC_BIT_GLOBAL_UV_MODE];
          if (reg_req.wdata[`CBC_BIT_GLOBAL_ENABLE]) begin
            next_s.ready = 1'b0;
          end
        end
        `CBC_ADDR_TIMEOUT_TIMER:    next_s.timeout = reg_req.wdata;
        `CBC_ADDR_CH_ENABLE_LOW:    next_s.ch_enable[15:0] = reg_req.wdata; // [RULE22]
        `CBC_ADDR_CH_ENABLE_HIGH:   next_s.ch_enable[17:16] = reg_req.wdata[1:0]; // [RULE22]
        `CBC_ADDR_PREBALANCE_TIMER: next_s.prebalance = reg_req.wdata;
        `CBC_ADDR_DISCHARGE_CTRL: begin
          next_s.discharge_ctrl = reg_req.wdata;
          if (reg_req.wdata == `CBC_KEY_DISCHARGE_ON) begin
            next_s.discharge_on = 1'b1; // [RULE7]
          end else if (reg_req.wdata == `CBC_KEY_DISCHARGE_OFF) begin
            next_s.discharge_on = 1'b0; // [RULE8]
          end
        end
        `CBC_ADDR_MON_ENABLE_LOW:   next_s.mon_enable[15:0] = reg_req.wdata;
        `CBC_ADDR_MON_ENABLE_HIGH:  next_s.mon_enable[17:16] = reg_req.wdata[1:0];
        default: begin
        end
      endcase
    end

    // Reads: fault flags clear on read, later sets win
    if (reg_req.rd) begin
      next_s.rdata = read_mux(s, reg_req.addr);
      if (reg_req.addr == `CBC_ADDR_FAULT_LOW) begin
        next_s.fault[15:0] = 16'h0000;
      end
      if (reg_req.addr == `CBC_ADDR_FAULT_HIGH) begin
        next_s.fault[17:16] = 2'h0;
      end
    end
    next_s.fault = next_s.fault | new_fault; // [RULE20]

    if (supply_low) begin
      next_s.discharge_on = 1'b0; // [RULE8]
    end

    // Channel completion; causes are merged and not recorded
    clear_all = expire // [RULE17] [RULE18]
              | (s.enable & s.timer_mode & done_evt.timers_all_expired)
              | (s.enable & done_evt.meas_valid & s.global_uv_mode // [RULE15]
                 & done_evt.global_uv_one)
              | (s.enable & done_evt.meas_valid & s.cell_uv_mode
                 & done_evt.cell_uv_all);
    clear_mask = new_fault | {CBC_CHANNELS{clear_all}}; // [RULE12] [RULE17]
    if (s.enable) begin
      clear_mask = clear_mask | done_evt.channel_done; // [RULE14]
    end
    next_s.ch_enable = next_s.ch_enable & ~clear_mask;

    if (expire) begin
      next_s.enable = 1'b0; // [RULE23]
      if (s.enable) begin
        next_s.ready = 1'b1; // [RULE16]
      end
    end

    if (s.enable && s.ch_enable == 18'h00000) begin
      next_s.enable = 1'b0; // [RULE16]
      next_s.ready  = 1'b1; // [RULE16]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s                <= '0;
      s.timeout        <= `CBC_RST_TIMEOUT_TIMER;
      s.prebalance     <= `CBC_RST_PREBALANCE_TIMER;
      s.ch_enable      <= `CBC_RST_CH_ENABLE;
      s.discharge_ctrl <= `CBC_RST_DISCHARGE_CTRL;
      s.mon_enable     <= `CBC_RST_MON_ENABLE;
    end else begin
      s <= next_s;
    end
  end

  // Channel timers wait during prebalance, junction pause and measurement pause
  assign channel_timer_hold = ~s.enable | (s.prebalance != 16'h0000) // [RULE24]
                            | s.junction_over | meas_pause; // [RULE3] [RULE5]
  assign balance_terminal   = s.switch_on;
  assign reg_rdata          = s.rdata;
  assign mode_config        = {s.global_uv_mode, s.cell_uv_mode, s.timer_mode, s.enable};

endmodule : cbc_balance_ctrl

`default_nettype wire

/* src/cbc_params.svh */
`ifndef CBC_PARAMS_SVH
`define CBC_PARAMS_SVH

// Register word addresses
`define CBC_ADDR_GLOBAL_CONFIG    16'h1000
`define CBC_ADDR_TIMEOUT_TIMER    16'h1001
`define CBC_ADDR_CH_ENABLE_LOW    16'h1002
`define CBC_ADDR_CH_ENABLE_HIGH   16'h1003
`define CBC_ADDR_PREBALANCE_TIMER 16'h1004
`define CBC_ADDR_DISCHARGE_CTRL   16'h1005
`define CBC_ADDR_MON_ENABLE_LOW   16'h1006
`define CBC_ADDR_MON_ENABLE_HIGH  16'h1007
`define CBC_ADDR_STATUS_LOW       16'h100D
`define CBC_ADDR_STATUS_HIGH      16'h100E
`define CBC_ADDR_SWITCH_LOW       16'h1010
`define CBC_ADDR_SWITCH_HIGH      16'h1011
`define CBC_ADDR_FAULT_LOW        16'h1012
`define CBC_ADDR_FAULT_HIGH       16'h1013

// Field positions
`define CBC_BIT_GLOBAL_ENABLE     0
`define CBC_BIT_TIMER_MODE        1
`define CBC_BIT_CELL_UV_MODE      2
`define CBC_BIT_GLOBAL_UV_MODE    3
`define CBC_BIT_READY             0

// Reset values
`define CBC_RST_GLOBAL_CONFIG     16'h0000
`define CBC_RST_TIMEOUT_TIMER     16'h0000
`define CBC_RST_CH_ENABLE         18'h00000
`define CBC_RST_PREBALANCE_TIMER  16'h0000
`define CBC_RST_DISCHARGE_CTRL    16'h2152
`define CBC_RST_MON_ENABLE        18'h3FFFF

// Discharge keys
`define CBC_KEY_DISCHARGE_ON      16'hDEAD
`define CBC_KEY_DISCHARGE_OFF     16'h2152

// Timing
`define CBC_CLK_HZ                20000000
`define CBC_TIMER_STEP_S          10
`define CBC_TIMER_STEP_CYCLES     (`CBC_TIMER_STEP_S * `CBC_CLK_HZ)

`endif

/* src/cbc_pkg.sv */
`default_nettype none

package cbc_pkg;

  localparam int CBC_CHANNELS = 18;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cbc_reg_req_t;

  typedef struct packed {
    logic [15:0] temp;
    logic        valid;
    logic [15:0] upper;
    logic [15:0] hyst;
  } cbc_junction_t;

  typedef struct packed {
    logic        meas_valid;
    logic        global_uv_one;
    logic        cell_uv_all;
    logic        timers_all_expired;
    logic [17:0] channel_done;
  } cbc_done_t;

  typedef struct packed {
    logic        enable;
    logic        timer_mode;
    logic        cell_uv_mode;
    logic        global_uv_mode;
    logic [15:0] timeout;
    logic [15:0] prebalance;
    logic [17:0] ch_enable;
    logic [15:0] discharge_ctrl;
    logic        discharge_on;
    logic        junction_over;
    logic        ready;
    logic [17:0] switch_on;
    logic [17:0] switch_on_prev;
    logic [17:0] fault;
    logic [17:0] mon_enable;
    logic [31:0] step_cnt;
    logic        step;
    logic [15:0] rdata;
  } cbc_state_t;

endpackage : cbc_pkg

`default_nettype wire

/* tb/cbc_balance_ctrl_props.sv */
`include "cbc_params.svh"
`default_nettype none

module cbc_balance_ctrl_props
  import cbc_pkg::*;
(
  // Clock and reset
  input wire logic          sys_clk,
  input wire logic          nrst,
  // Watched inputs
  input wire cbc_reg_req_t  reg_req,
  input wire cbc_junction_t junction,
  input wire logic          meas_pause,
  input wire logic          supply_low,
  input wire logic          battery_overvoltage_flag,
  // Watched outputs
  input wire logic [15:0]   reg_rdata,
  input wire logic [17:0]   balance_terminal,
  input wire logic          channel_timer_hold,
  input wire logic [3:0]    mode_config
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_key_on;
    reg_req.wr && reg_req.addr == `CBC_ADDR_DISCHARGE_CTRL
      && reg_req.wdata == `CBC_KEY_DISCHARGE_ON;
  endsequence
  sequence s_quiet;
    !supply_low && !battery_overvoltage_flag && !meas_pause;
  endsequence
  sequence s_idle_cfg;
    !mode_config[0] && !reg_req.wr;
  endsequence

  key_starts_a: assert property (s_key_on ##0 s_quiet ##1 s_quiet
    |=> balance_terminal != 18'h00000)
    else $error("discharge key left switches open");
  low_stops_a: assert property (supply_low ##0 s_idle_cfg
    |=> ##1 balance_terminal == 18'h00000)
    else $error("supply low did not open switches");
  ov_stops_a: assert property (battery_overvoltage_flag ##0 s_idle_cfg |=> !balance_terminal)
    else $error("overvoltage did not suspend discharge");
  pause_hold_a: assert property (meas_pause |-> channel_timer_hold)
    else $error("timers run during pause");
  hot_hold_a: assert property (junction.valid && junction.temp > junction.upper |=> channel_timer_hold)
    else $error("timers run while hot");
  idle_hold_a: assert property (!mode_config[0] |-> channel_timer_hold)
    else $error("timers run without enable");
  cfg_read_a: assert property (reg_req.rd && !reg_req.wr && reg_req.addr == `CBC_ADDR_GLOBAL_CONFIG
    |=> reg_rdata[3:0] == $past(mode_config))
    else $error("config readback differs");
  high_read_a: assert property (reg_req.rd && reg_req.addr == `CBC_ADDR_CH_ENABLE_HIGH
    |=> reg_rdata[15:2] == 14'h0000)
    else $error("high enable word has extra bits");
endmodule : cbc_balance_ctrl_props

bind cbc_balance_ctrl cbc_balance_ctrl_props i_props (.sys_clk, .nrst, .reg_req, .junction,
  .meas_pause, .supply_low, .battery_overvoltage_flag, .reg_rdata, .balance_terminal,
  .channel_timer_hold, .mode_config);

`default_nettype wire

/* tb/cbc_balance_ctrl_test.sv */
`default_nettype none

module cbc_balance_ctrl_test
  import cbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STEP = 20;
  localparam logic [15:0] RA [9] = '{16'h1000, 16'h1001, 16'h1002, 16'h1003, 16'h1004,
    16'h1005, 16'h1006, 16'h1007, 16'h1008};
  localparam logic [15:0] RV [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h2152, 16'hFFFF, 16'h0003, 16'h0000};
  logic          sys_clk;
  logic          nrst;
  logic          pause;
  logic          slow;
  logic          ovf;
  logic          hold;
  logic [3:0]    mode;
  logic [15:0]   rdata;
  logic [15:0]   q;
  logic [15:0]   v;
  logic [17:0]   flip;
  logic [17:0]   oc;
  logic [17:0]   ol;
  logic [17:0]   term;
  cbc_reg_req_t  req;
  cbc_junction_t jt;
  cbc_done_t     dn;
  int            n_fail;
  int            checks;
  wire logic [17:0] sw = term ^ flip;

  cbc_host_model i_host (.sys_clk, .reg_req(req), .reg_rdata(rdata));
  cbc_balance_ctrl #(.STEP_CYCLES(STEP)) i_dut (.sys_clk, .nrst, .reg_req(req),
    .reg_rdata(rdata), .junction(jt), .meas_pause(pause), .supply_low(slow),
    .battery_overvoltage_flag(ovf), .done_evt(dn), .switch_closed(sw),
    .switch_overcurrent(oc), .switch_open_load(ol), .balance_terminal(term),
    .channel_timer_hold(hold), .mode_config(mode));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    i_host.rd(a, q);
    cmp({2'b00, q}, {2'b00, exp});
  endtask : rdc
  task automatic see(input int n, input logic [17:0] exp);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp(term, exp);
  endtask : see
  task automatic junc(input logic [15:0] t);
    @(posedge sys_clk);
    jt <= '{t, 1'b1, 16'h0064, 16'h000A};
    @(posedge sys_clk);
    jt.valid <= 1'b0;
  endtask : junc
  // Timeout must keep counting through a balancing pause
  task automatic to_check;
    i_host.wr(16'h1001, 16'h0003);
    repeat (STEP - 1) @(posedge sys_clk);
    rdc(16'h1001, 16'h0002);
    i_host.wr(16'h1001, 16'h0000);
  endtask : to_check
  task automatic complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  // Bounded wait for the global enable to drop
  task automatic poll_off;
    for (int i = 0; i < 200; i++) begin
      i_host.rd(16'h1000, v);
      if (v[0] === 1'b0) return;
    end
    n_fail++;
    complete_run;
  endtask : poll_off

  initial begin
    repeat (30000) @(posedge sys_clk);
    n_fail++;
    complete_run;
  end

  initial begin
    void'($urandom(32'hFEE41DBC));
    nrst = 1'b0;
    pause = 1'b0;
    slow = 1'b0;
    ovf = 1'b0;
    flip = '0;
    oc = '0;
    ol = '0;
    dn = '0;
    jt = '{16'h0000, 1'b0, 16'h0064, 16'h000A};
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (RA[i]) rdc(RA[i], RV[i]);
    repeat (12) begin
      v = 16'($urandom);
      i_host.wr(16'h1002, v);
      rdc(16'h1002, v);
      i_host.wr(16'h1003, v);
      rdc(16'h1003, v & 16'h0003);
      i_host.wr(16'h1004, v);
      rdc(16'h1004, v);
    end
    i_host.wr(16'h1004, 16'h0000);
    i_host.wr(16'h1005, 16'hDEAD);
    see(1, 18'h3FFFF);
    rdc(16'h1010, 16'hFFFF);
    i_host.wr(16'h1001, 16'h0003);
    repeat (5 * STEP) @(posedge sys_clk);
    rdc(16'h1001, 16'h0003);
    @(posedge sys_clk) ovf <= 1'b1;
    see(2, 18'h00000);
    repeat (3 * STEP + 5) @(posedge sys_clk);
    rdc(16'h1001, 16'h0000);
    @(posedge sys_clk) ovf <= 1'b0;
    see(2, 18'h3FFFF);
    @(posedge sys_clk) oc <= 18'h00020;
    see(3, 18'h3FFDF);
    @(posedge sys_clk) oc <= '0;
    rdc(16'h1012, 16'h0020);
    i_host.wr(16'h1006, 16'hFFBF);
    @(posedge sys_clk);
    ol <= 18'h00040;
    flip <= 18'h00080;
    repeat (4) @(posedge sys_clk);
    rdc(16'h1012, 16'h0080);
    @(posedge sys_clk);
    ol <= '0;
    flip <= '0;
    i_host.wr(16'h1005, 16'h2152);
    see(1, 18'h00000);
    i_host.wr(16'h1005, 16'hDEAD);
    @(posedge sys_clk) slow <= 1'b1;
    @(posedge sys_clk) slow <= 1'b0;
    see(1, 18'h00000);
    i_host.rd(16'h1012, v);
    i_host.wr(16'h1006, 16'hFFFF);
    i_host.wr(16'h1002, 16'h0F00);
    i_host.wr(16'h1004, 16'h0001);
    i_host.wr(16'h1000, 16'h0001);
    see(1, 18'h00000);
    repeat (STEP) @(posedge sys_clk);
    see(2, 18'h00F00);
    @(posedge sys_clk) pause <= 1'b1;
    see(2, 18'h00000);
    cmp({17'h00000, hold}, 18'h00001);
    to_check;
    @(posedge sys_clk) pause <= 1'b0;
    see(2, 18'h00F00);
    junc(16'h0065 + 16'($urandom_range(40)));
    see(2, 18'h00000);
    to_check;
    junc(16'h005B);
    see(2, 18'h00000);
    junc(16'h005A);
    see(2, 18'h00F00);
    junc(16'h0064);
    see(2, 18'h00F00);
    @(posedge sys_clk) dn.channel_done <= 18'h3FFFF;
    poll_off;
    rdc(16'h1002, 16'h0000);
    rdc(16'h100E, 16'h0004);
    @(posedge sys_clk) dn.channel_done <= '0;
    i_host.wr(16'h1002, 16'h0003);
    i_host.wr(16'h1001, 16'h0002);
    i_host.wr(16'h1000, 16'h0001);
    see(2, 18'h00003);
    poll_off;
    see(1, 18'h00000);
    rdc(16'h100E, 16'h0004);
    rdc(16'h1002, 16'h0000);
    for (int m = 0; m < 3; m++) begin
      i_host.wr(16'h1002, 16'h0030);
      i_host.wr(16'h1000, 16'h0001 | (16'h0002 << m));
      @(posedge sys_clk);
      dn <= '{1'b1, m == 1, m == 0, m == 2, 18'h00000};
      @(posedge sys_clk);
      dn <= '0;
      rdc(16'h1002, 16'h0030);
      @(posedge sys_clk);
      dn <= '{1'b1, m == 2, m == 1, m == 0, 18'h00000};
      @(posedge sys_clk);
      dn <= '0;
      poll_off;
      rdc(16'h1002, 16'h0000);
    end
    complete_run;
  end
endmodule : cbc_balance_ctrl_test

`default_nettype wire

/* tb/cbc_host_model.sv */
`default_nettype none

module cbc_host_model
  import cbc_pkg::*;
(
  // Clock
  input  wire logic        sys_clk,
  // Register port
  output var cbc_reg_req_t reg_req,
  input  wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial reg_req = '0;

  // Software starts and stops discharge and clears flags through these
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    reg_req <= '0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge sys_clk);
    reg_req <= '0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd
endmodule : cbc_host_model

`default_nettype wire
